// ---- pkg/aga_pkg.sv ----
package aga_pkg;
	localparam int ADDR_W = 64;
	localparam int DISP_W = 32;
	localparam int GPR_CNT = 16;
	localparam int GPR_SEL_W = 4;
	localparam int PORT_W = 16;
	localparam int LANE_W = 4;
	localparam int BUS_BYTES = 8;
	// Size codes: byte, word, dword, qword, dqword
	typedef enum logic [2:0] {
		AGA_SZ_B = 3'h0,
		AGA_SZ_W = 3'h1,
		AGA_SZ_D = 3'h2,
		AGA_SZ_Q = 3'h3,
		AGA_SZ_DQ = 3'h4
	} aga_size_t;
	typedef enum logic [1:0] {
		AGA_DISP_NONE = 2'h0,
		AGA_DISP_8 = 2'h1,
		AGA_DISP_16 = 2'h2,
		AGA_DISP_32 = 2'h3
	} aga_disp_t;
	// Scale codes 1,2,4,8 as shift amounts
	localparam logic [1:0] SCALE_MAX_SH = 2'h3;
	localparam logic [4:0] DQ_BYTES = 5'h10;
	localparam logic [3:0] DQ_ALIGN_MASK = 4'hF;
	localparam logic [2:0] QW_ALIGN_MASK = 3'h7;
	localparam logic [1:0] DW_ALIGN_MASK = 2'h3;
	localparam logic [1:0] LANE4_MASK = 2'h3;
	localparam logic [2:0] LANE8_MASK = 3'h7;
	typedef enum logic [2:0] {
		AGA_ST_IDLE = 3'b001,
		AGA_ST_FIRST = 3'b010,
		AGA_ST_SECOND = 3'b100
	} aga_state_t;
endpackage : aga_pkg

// ---- pkg/aga_req_if.sv ----
`timescale 1ns/1ps
`default_nettype none
interface aga_req_if;
	logic [aga_pkg::ADDR_W-1:0] ea;
	logic [4:0] nbytes;
	logic valid;
	logic ready;
	logic [aga_pkg::ADDR_W-1:0] cyc_addr;
	logic [4:0] cyc_bytes;
	logic cyc_valid;
	logic cyc_last;
	modport src (output ea, output nbytes, output valid, input ready);
	modport split (input ea, input nbytes, input valid, output ready,
		output cyc_addr, output cyc_bytes, output cyc_valid, output cyc_last);
endinterface : aga_req_if
`default_nettype wire

// ---- rtl/aga_splitter.sv ----
`timescale 1ns/1ps
`default_nettype none
// Breaks one access into at most two bus cycles at a lane boundary
module aga_splitter (
	input wire logic sys_clk,
	input wire logic reset_n,
	input wire logic [2:0] lane_log2,
	input wire logic bus_ready,
	aga_req_if.split rq
);
	logic [aga_pkg::ADDR_W-1:0] addr2;
	logic [4:0] bytes2;
	logic [4:0] first_bytes;
	logic [4:0] room;
	logic [aga_pkg::ADDR_W-1:0] lane_mask;
	aga_pkg::aga_state_t state;
	assign lane_mask = (64'h1 << lane_log2) - 64'h1;
	assign room = 5'((64'h1 << lane_log2) - (rq.ea & lane_mask));
	assign first_bytes = (rq.nbytes > room) ? room : rq.nbytes;
	assign rq.ready = (state == aga_pkg::AGA_ST_IDLE);
	//==========================================
	// Sequence
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			state <= aga_pkg::AGA_ST_IDLE;
			addr2 <= '0;
			bytes2 <= '0;
			rq.cyc_addr <= '0;
			rq.cyc_bytes <= '0;
			rq.cyc_valid <= 1'b0;
			rq.cyc_last <= 1'b0;
		end else begin
			case (state)
				aga_pkg::AGA_ST_IDLE: begin
					if (rq.valid) begin
						rq.cyc_addr <= rq.ea;
						rq.cyc_bytes <= first_bytes;
						rq.cyc_valid <= 1'b1;
						rq.cyc_last <= (first_bytes == rq.nbytes);
						addr2 <= rq.ea + 64'(first_bytes);
						bytes2 <= rq.nbytes - first_bytes;
						state <= aga_pkg::AGA_ST_FIRST;
					end
				end
				aga_pkg::AGA_ST_FIRST: begin
					if (bus_ready) begin
						if (rq.cyc_last) begin
							rq.cyc_valid <= 1'b0;
							state <= aga_pkg::AGA_ST_IDLE;
						end else begin
							rq.cyc_addr <= addr2;
							rq.cyc_bytes <= bytes2;
							rq.cyc_last <= 1'b1;
							state <= aga_pkg::AGA_ST_SECOND;
						end
					end
				end
				aga_pkg::AGA_ST_SECOND: begin
					if (bus_ready) begin
						rq.cyc_valid <= 1'b0;
						rq.cyc_last <= 1'b0;
						state <= aga_pkg::AGA_ST_IDLE;
					end
				end
				default: state <= aga_pkg::AGA_ST_IDLE;
			endcase
		end
	end
endmodule : aga_splitter
`default_nettype wire

// ---- rtl/aga_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module aga_top #(
	parameter int GPR_CNT = aga_pkg::GPR_CNT
) (
	input wire logic sys_clk,
	input wire logic reset_n,
	input wire logic req_valid,
	input wire logic req_io,
	input wire logic io_from_reg,
	input wire logic [aga_pkg::PORT_W-1:0] io_imm_port,
	input wire logic [aga_pkg::PORT_W-1:0] port_index_data_register,
	input wire logic ip_relative,
	input wire logic [aga_pkg::ADDR_W-1:0] instruction_pointer,
	input wire logic [aga_pkg::DISP_W-1:0] disp,
	input wire logic [1:0] disp_size,
	input wire logic base_en,
	input wire logic [aga_pkg::GPR_SEL_W-1:0] base_sel,
	input wire logic index_en,
	input wire logic [aga_pkg::GPR_SEL_W-1:0] index_sel,
	input wire logic [1:0] scale_sh,
	input wire logic [2:0] op_size,
	input wire logic need_align,
	input wire logic [aga_pkg::ADDR_W*GPR_CNT-1:0] gpr_file,
	input wire logic bus_ready,
	output logic req_ready,
	output logic [aga_pkg::ADDR_W-1:0] bus_addr,
	output logic [4:0] bus_bytes,
	output logic bus_valid,
	output logic bus_last,
	output logic bus_io,
	output logic [aga_pkg::ADDR_W-1:0] eff_addr,
	output logic natural_aligned,
	output logic general_protection_fault
);
	logic [aga_pkg::ADDR_W-1:0] disp_ext;
	logic [aga_pkg::ADDR_W-1:0] base_val;
	logic [aga_pkg::ADDR_W-1:0] index_val;
	logic [aga_pkg::ADDR_W-1:0] next_ea;
	logic [4:0] nbytes;
	logic [2:0] lane_log2;
	logic aligned;
	logic misalign_fault;
	logic io_q;
	logic take;
	logic dq_mem;
	logic [aga_pkg::PORT_W-1:0] io_port;
	logic [aga_pkg::ADDR_W-1:0] ip_disp;
	logic [aga_pkg::ADDR_W-1:0] scaled_index;
	logic [1:0] pick_en;
	logic [aga_pkg::GPR_SEL_W-1:0] pick_sel [2];
	logic [aga_pkg::ADDR_W-1:0] pick_val [2];
	aga_req_if rq ();

	//==========================================
	// Component select
	// sign-extend displacement
	always_comb begin
		case (aga_pkg::aga_disp_t'(disp_size))
			aga_pkg::AGA_DISP_8: disp_ext = 64'(signed'(disp[7:0]));
			aga_pkg::AGA_DISP_16: disp_ext = 64'(signed'(disp[15:0]));
			aga_pkg::AGA_DISP_32: disp_ext = 64'(signed'(disp[31:0]));
			default: disp_ext = '0;
		endcase
	end

	// Slot 0 is the base, slot 1 the index
	assign pick_en = {index_en, base_en};
	assign pick_sel[0] = base_sel;
	assign pick_sel[1] = index_sel;

	for (genvar g = 0; g < 2; g++) begin : g_pick
		assign pick_val[g] = pick_en[g] ?
			gpr_file[pick_sel[g]*aga_pkg::ADDR_W +: aga_pkg::ADDR_W] : '0;
	end
	assign base_val = pick_val[0];
	assign index_val = pick_val[1];

	//==========================================
	// Address sum
	// port source select
	assign io_port = io_from_reg ? port_index_data_register : io_imm_port;
	assign ip_disp = 64'(signed'(disp));
	// scaled index
	// Shift of 0..3 gives x1, x2, x4, x8; scale never negative
	assign scaled_index = index_val << scale_sh;

	always_comb begin
		if (req_io) begin
			// Ports live in the low 16 bits only
			next_ea = 64'(io_port);
		end else if (ip_relative) begin
			next_ea = instruction_pointer + ip_disp;
		end else begin
			next_ea = disp_ext + base_val + scaled_index;
		end
	end

	//==========================================
	// Size and alignment
	// operand width in bytes
	always_comb begin
		case (aga_pkg::aga_size_t'(op_size))
			aga_pkg::AGA_SZ_W: nbytes = 5'h02;
			aga_pkg::AGA_SZ_D: nbytes = 5'h04;
			aga_pkg::AGA_SZ_Q: nbytes = 5'h08;
			aga_pkg::AGA_SZ_DQ: nbytes = aga_pkg::DQ_BYTES;
			default: nbytes = 5'h01;
		endcase
	end

	always_comb begin
		case (aga_pkg::aga_size_t'(op_size))
			aga_pkg::AGA_SZ_W: aligned = ~next_ea[0];
			aga_pkg::AGA_SZ_D: aligned = (next_ea[1:0] & aga_pkg::DW_ALIGN_MASK) == 2'h0;
			aga_pkg::AGA_SZ_Q: aligned = (next_ea[2:0] & aga_pkg::QW_ALIGN_MASK) == 3'h0;
			aga_pkg::AGA_SZ_DQ: aligned = (next_ea[3:0] & aga_pkg::DQ_ALIGN_MASK) == 4'h0;
			default: aligned = 1'b1;
		endcase
	end

	// I/O ports use 4-byte lanes
	// Quadword and dqword memory use 8-byte lanes
	always_comb begin
		lane_log2 = 3'h2;
		if (!req_io) begin
			case (aga_pkg::aga_size_t'(op_size))
				aga_pkg::AGA_SZ_Q: lane_log2 = 3'h3;
				aga_pkg::AGA_SZ_DQ: lane_log2 = 3'h3;
				default: lane_log2 = 3'h2;
			endcase
		end
	end

	// Only memory dqwords can demand 16-byte alignment
	assign dq_mem = !req_io && (aga_pkg::aga_size_t'(op_size) == aga_pkg::AGA_SZ_DQ);
	assign misalign_fault = need_align && dq_mem &&
		((next_ea[3:0] & aga_pkg::DQ_ALIGN_MASK) != 4'h0);

	//==========================================
	// Result registers
	assign take = req_valid && req_ready;

	// Address and alignment flag stand until the next take
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			eff_addr <= '0;
			natural_aligned <= 1'b0;
		end else if (take) begin
			eff_addr <= next_ea;
			natural_aligned <= aligned;
		end
	end

	// one-cycle fault pulse
	// A held faulting request is taken every cycle and keeps the fault high
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			general_protection_fault <= 1'b0;
		end else begin
			general_protection_fault <= take && misalign_fault;
		end
	end

	// Kind of the access now on the bus
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			io_q <= 1'b0;
		end else if (take) begin
			io_q <= req_io;
		end
	end

	// Faulting access never reaches the bus
	assign rq.valid = req_valid && !misalign_fault;
	assign rq.ea = next_ea;
	// unaligned dqword goes through split path
	// first cycle carries lowest address, low bytes
	assign rq.nbytes = nbytes;
	assign req_ready = rq.ready;

	aga_splitter u_split (
		.sys_clk(sys_clk),
		.reset_n(reset_n),
		.lane_log2(lane_log2),
		.bus_ready(bus_ready),
		.rq(rq)
	);

	// addresses are unsigned binary on the bus
	assign bus_addr = rq.cyc_addr;
	assign bus_bytes = rq.cyc_bytes;
	assign bus_valid = rq.cyc_valid;
	assign bus_last = rq.cyc_last;
	assign bus_io = io_q;
endmodule : aga_top
`default_nettype wire

// ---- tb/aga_bus_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module aga_bus_model (
	input wire logic sys_clk,
	input wire logic reset_n,
	input wire logic stall,
	input wire logic bus_valid,
	output logic bus_ready
);
	// ====================
	// Slow mode accepts every other cycle
	logic tick;
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) tick <= 1'b0;
		else tick <= !tick;
	end
	assign bus_ready = bus_valid && (!stall || tick);
endmodule : aga_bus_model
`default_nettype wire

// ---- tb/aga_properties.sv ----
`timescale 1ns/1ps
`default_nettype none
module aga_checker (
	input wire logic sys_clk,
	input wire logic reset_n,
	input wire logic req_valid,
	input wire logic req_ready,
	input wire logic req_io,
	input wire logic ip_relative,
	input wire logic [63:0] instruction_pointer,
	input wire logic [31:0] disp,
	input wire logic bus_ready,
	input wire logic [63:0] bus_addr,
	input wire logic [4:0] bus_bytes,
	input wire logic bus_valid,
	input wire logic bus_last,
	input wire logic bus_io,
	input wire logic [63:0] eff_addr,
	input wire logic general_protection_fault
);
	// ====================
	// Helpers
	logic [63:0] ip_sum;
	always_ff @(posedge sys_clk) begin
		ip_sum <= instruction_pointer + {{32{disp[31]}}, disp};
	end
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!reset_n);
	sequence s_first_taken;
		bus_valid && bus_ready && !bus_last;
	endsequence
	sequence s_second_shown;
		bus_valid && bus_last;
	endsequence
	// ====================
	// Properties
	chk_bus_hold: assert property (
		bus_valid && !bus_ready |=> bus_valid && $stable(bus_addr) && $stable(bus_bytes))
		else $error("bus cycle changed before accept");
	chk_split_next: assert property (
		s_first_taken |=> s_second_shown ##0 bus_addr == $past(bus_addr) + 64'($past(bus_bytes)))
		else $error("second bus cycle address wrong");
	chk_fault_pulse: assert property (
		!$past(req_valid && req_ready) |-> !general_protection_fault)
		else $error("fault without a taken request");
	chk_fault_quiet: assert property (
		general_protection_fault |-> !bus_valid && req_ready)
		else $error("faulting access reached the bus");
	chk_fault_addr: assert property (
		general_protection_fault |-> eff_addr[3:0] != 4'h0)
		else $error("fault on aligned address");
	chk_busy_refuse: assert property (
		bus_valid |-> !req_ready)
		else $error("request taken during bus sequence");
	chk_first_addr: assert property (
		$rose(bus_valid) && !bus_io |-> bus_addr == eff_addr)
		else $error("first bus cycle not at lowest address");
	chk_ip_sum: assert property (
		req_valid && req_ready && ip_relative && !req_io |=> eff_addr == ip_sum)
		else $error("pointer-relative address wrong");
	chk_io_flag: assert property (
		req_valid && req_ready |=> bus_io == $past(req_io))
		else $error("I/O flag does not follow request");
endmodule : aga_checker
bind aga_top aga_checker u_chk (
	.sys_clk(sys_clk),
	.reset_n(reset_n),
	.req_valid(req_valid),
	.req_ready(req_ready),
	.req_io(req_io),
	.ip_relative(ip_relative),
	.instruction_pointer(instruction_pointer),
	.disp(disp),
	.bus_ready(bus_ready),
	.bus_addr(bus_addr),
	.bus_bytes(bus_bytes),
	.bus_valid(bus_valid),
	.bus_last(bus_last),
	.bus_io(bus_io),
	.eff_addr(eff_addr),
	.general_protection_fault(general_protection_fault)
);
`default_nettype wire

// ---- tb/testbench.sv ----
`timescale 1ns/1ps
`default_nettype none
module testbench;
	logic sys_clk = 0, reset_n = 0, req_valid = 0, req_io = 0, io_from_reg = 0;
	logic ip_relative = 0, base_en = 0, index_en = 0, need_align = 0, stall = 0, flt;
	logic [15:0] io_imm_port = 0, port_index_data_register = 0;
	logic [63:0] instruction_pointer = 0, e;
	logic [31:0] disp = 0;
	logic [1:0] disp_size = 0, scale_sh = 0;
	logic [3:0] base_sel = 0, index_sel = 0;
	logic [2:0] op_size = 0;
	logic [1023:0] gpr_file = 0;
	logic req_ready, bus_ready, bus_valid, bus_last, bus_io, natural_aligned;
	logic general_protection_fault;
	logic [63:0] bus_addr, eff_addr;
	logic [4:0] bus_bytes;
	logic [63:0] got_a[$];
	logic [4:0] got_n[$];
	int bad_count = 0, n_compared = 0;
	aga_top DUT (
		.sys_clk(sys_clk),
		.reset_n(reset_n),
		.req_valid(req_valid),
		.req_io(req_io),
		.io_from_reg(io_from_reg),
		.io_imm_port(io_imm_port),
		.port_index_data_register(port_index_data_register),
		.ip_relative(ip_relative),
		.instruction_pointer(instruction_pointer),
		.disp(disp),
		.disp_size(disp_size),
		.base_en(base_en),
		.base_sel(base_sel),
		.index_en(index_en),
		.index_sel(index_sel),
		.scale_sh(scale_sh),
		.op_size(op_size),
		.need_align(need_align),
		.gpr_file(gpr_file),
		.bus_ready(bus_ready),
		.req_ready(req_ready),
		.bus_addr(bus_addr),
		.bus_bytes(bus_bytes),
		.bus_valid(bus_valid),
		.bus_last(bus_last),
		.bus_io(bus_io),
		.eff_addr(eff_addr),
		.natural_aligned(natural_aligned),
		.general_protection_fault(general_protection_fault)
	);
	aga_bus_model u_bus (.sys_clk(sys_clk), .reset_n(reset_n), .stall(stall),
		.bus_valid(bus_valid), .bus_ready(bus_ready));
	initial forever #2.5 sys_clk = ~sys_clk;
	// ====================
	// Shared tasks
	task automatic chk(input string what, input logic [63:0] seen, exp);
		n_compared++;
		if (seen !== exp) begin
			bad_count++;
			$display("[ERR] %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk
	task automatic close_out;
		if (bad_count == 0 && n_compared > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask : close_out
	task automatic go;
		bit done;
		got_a = {};
		got_n = {};
		req_valid = 1;
		for (int k = 0; k < 20 && !req_ready; k++) @(negedge sys_clk);
		@(negedge sys_clk);
		req_valid = 0;
		flt = general_protection_fault;
		done = 0;
		for (int k = 0; k < 20 && !done; k++) begin
			if (bus_valid && bus_ready) begin
				got_a.push_back(bus_addr);
				got_n.push_back(bus_bytes);
				done = bus_last;
			end
			@(negedge sys_clk);
		end
	endtask : go
	// ====================
	// Scenarios
	task automatic ea_case(input logic be, ie, input logic [3:0] bs, is,
		input logic [1:0] sc, dsz, input logic [31:0] d, input logic [63:0] x);
		{base_en, index_en, base_sel, index_sel, scale_sh} = {be, ie, bs, is, sc};
		{disp_size, disp, op_size} = {dsz, d, 3'h0};
		go();
		chk("eff_addr", eff_addr, x);
		chk("bus_addr", got_a[0], x);
		chk("mem flag", bus_io, 0);
	endtask : ea_case
	task automatic split_case(input logic [2:0] sz, input logic [31:0] d,
		input logic [63:0] a1, input logic [4:0] n0, n1);
		{base_en, index_en, disp_size, disp, op_size} = {2'h0, 2'h3, d, sz};
		go();
		chk("first addr", got_a[0], 64'(d));
		chk("first bytes", got_n[0], n0);
		chk("cycles", got_a.size(), n1 ? 2 : 1);
		chk("aligned", natural_aligned, (d & ((32'h1 << sz) - 32'h1)) == 32'h0);
		if (n1) chk("second addr", got_a[1], a1);
		if (n1) chk("second bytes", got_n[1], n1);
	endtask : split_case
	task automatic t_dq;
		need_align = 1;
		split_case(3'h4, 32'h10, 64'h18, 5'h8, 5'h8);
		chk("aligned fault", flt, 0);
		{disp} = 32'h4;
		go();
		chk("fault", flt, 1);
		chk("fault cycles", got_a.size(), 0);
		need_align = 0;
		go();
		chk("dq fault", flt, 0);
		chk("dq aligned", natural_aligned, 0);
		chk("dq cycles", got_a.size(), 2);
		chk("dq bytes", got_n[0] + got_n[1], 16);
	endtask : t_dq
	task automatic t_io;
		{req_io, op_size, port_index_data_register, io_imm_port} = {4'h9, 32'hBEEF_0080};
		for (int r = 1; r >= 0; r--) begin
			io_from_reg = r[0];
			go();
			chk("io port", got_a[0], r ? 64'hBEEF : 64'h80);
			chk("io flag", bus_io, 1);
		end
		req_io = 0;
	endtask : t_io
	initial begin
		#100us;
		bad_count++;
		close_out();
	end
	initial begin
		gpr_file[64*3 +: 64] = 64'h1000;
		gpr_file[64*5 +: 64] = 64'hFFFF_FFFF_FFFF_FFFE;
		gpr_file[64*15 +: 64] = 64'h10;
		gpr_file[64*7 +: 64] = 64'hFFFF_FFFF_FFFF_FFF8;
		repeat (3) @(negedge sys_clk);
		reset_n = 1;
		for (int s = 0; s < 4; s++) begin
			e = 64'h1000 + (64'hFFFF_FFFF_FFFF_FFFE << s) - 64'h10;
			ea_case(1, 1, 3, 5, s[1:0], 2'h1, 32'hF0, e);
		end
		ea_case(1, 0, 3, 5, 2'h3, 2'h0, 32'h0, 64'h1000);
		ea_case(0, 1, 3, 15, 2'h2, 2'h2, 32'h8000, 64'hFFFF_FFFF_FFFF_8040);
		ea_case(1, 0, 7, 5, 2'h0, 2'h3, 32'h10, 64'h8);
		ip_relative = 1;
		instruction_pointer = 64'h40_1000;
		ea_case(0, 0, 0, 0, 2'h0, 2'h3, 32'hFFFF_FF00, 64'h40_0F00);
		ip_relative = 0;
		stall = 1;
		split_case(3'h2, 32'h6, 64'h8, 5'h2, 5'h2);
		split_case(3'h1, 32'h7, 64'h8, 5'h1, 5'h1);
		split_case(3'h3, 32'h8, 64'h0, 5'h8, 5'h0);
		split_case(3'h3, 32'hC, 64'h10, 5'h4, 5'h4);
		t_dq();
		t_io();
		close_out();
	end
endmodule : testbench
`default_nettype wire
